// ===== common/ebpc_pkg.sv
// Functional notes
// - external bus eight or sixteen bits wide
// - byte reads: even 1/0/1, odd 0/1/1
// - byte writes: even 1/0/0, odd 0/1/0
// - word reads: even 0/0/1, swapped 1/1/1
// - word writes: even 0/0/0, swapped 1/1/0
// - strobe and A0 high only for RAM
// - swapped access: addressed byte on low half
// - narrow-following bit mixes eight/sixteen peripherals
// - following space narrow when bit set
// - peripheral mode removes first sixteen registers
// - expanded modes remove port A/B registers
// - emulation bit removes port E data/direction in expanded modes
// - port E data absent peripheral or emulated
// - port A carries high address/data
// - port B carries low address/data; narrow accesses keep only the low address on it
// - unused ports are general-purpose I/O
// - direction bit: 0 input, 1 output
// - port E pins carry bus control
// - one bit enables pull-ups on inputs
// - port E bits 1:0 input only
package ebpc_pkg;
  localparam logic [15:0] OFS_PORT_A_DATA = 16'h0000;
  localparam logic [15:0] OFS_PORT_B_DATA = 16'h0001;
  localparam logic [15:0] OFS_PORT_A_DIR  = 16'h0002;
  localparam logic [15:0] OFS_PORT_B_DIR  = 16'h0003;
  localparam logic [15:0] OFS_PORT_E_DATA = 16'h0008;
  localparam logic [15:0] OFS_PORT_E_DIR  = 16'h0009;
  localparam logic [15:0] OFS_PORT_E_ASGN = 16'h000A;
  localparam logic [15:0] OFS_MODE_CTRL   = 16'h000B;
  localparam logic [15:0] OFS_PULL_CTRL   = 16'h000C;
  localparam logic [15:0] OFS_MISC_CTRL   = 16'h000D;
  localparam logic [15:0] OFS_BUS_STATUS  = 16'h000E;
  localparam logic [15:0] EXPANSION_REGS  = 16'h0010;
  localparam logic [15:0] FOLLOW_BASE     = 16'h0200;
  localparam logic [15:0] FOLLOW_SIZE     = 16'h0200;
  localparam logic [7:0]  RST_PORT        = 8'h00;
  localparam logic [7:0]  RST_ASGN        = 8'h00;
  localparam logic [7:0]  RST_MODE        = 8'h00;
  localparam logic [7:0]  RST_MISC        = 8'h00;
  localparam logic [7:0]  PORT_E_OUT_MASK = 8'hFC;
  // assignment register bit positions
  localparam int ASGN_DBE   = 7;
  localparam int ASGN_PIPE  = 5;
  localparam int ASGN_E_CLOCK_OUT  = 4;
  localparam int ASGN_STRB  = 3;
  localparam int ASGN_RDW   = 2;
  // mode, misc and pull register bit positions; E clock divider
  localparam int MODE_EME   = 0;
  localparam int MODE_M0    = 5;
  localparam int MISC_NARR  = 0;
  localparam int PULL_PUPE  = 0;
  localparam int E_CLOCK_OUT_DIV   = 2;

  typedef enum logic [2:0] {
    EBPC_SINGLE   = 3'b000,
    EBPC_EXP_NARR = 3'b001,
    EBPC_PERIPH   = 3'b010,
    EBPC_EXP_WIDE = 3'b011
  } ebpc_mode_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        wide;
    logic        ramHit;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebpc_req_type;

  typedef struct packed {
    logic strobeN;
    logic a0;
    logic readWrite;
  } ebpc_ctl_type;
endpackage : ebpc_pkg

// ===== rtl/ebpc_encode.sv
`timescale 1ns/100ps
// access-type encoder for the strobe, A0 and read/write pins
module ebpc_encode (
  input  wire logic                  wide,     // 16-bit access
  input  wire logic                  write,    // write access
  input  wire logic                  odd,      // odd byte address
  input  wire logic                  ramHit,   // internal RAM target
  output      ebpc_pkg::ebpc_ctl_type ctl      // encoded pins
);
  always_comb begin
    ctl.readWrite = ~write;
    ctl.a0        = odd;
    if (!wide) begin
      ctl.strobeN = ~odd;
    end else if (odd && ramHit) begin
      ctl.strobeN = 1'b1;
    end else begin
      ctl.strobeN = 1'b0;
      ctl.a0      = 1'b0;
    end
  end
endmodule : ebpc_encode

// ===== rtl/ebpc_port_control.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
// external bus port control: port muxing, map removal, GPIO
module ebpc_port_control (
  input  wire logic                 ref_clk,      // 40 MHz clock
  input  wire logic                 reset,        // async reset
  input  wire logic [15:0]          regAddr,      // register address
  input  wire logic [7:0]           regWdata,     // write data
  input  wire logic                 regWr,        // write strobe
  input  wire logic                 regRd,        // read strobe
  output      logic [7:0]           regRdata,     // read data
  output      logic                 regExternal,  // access went outside
  input  wire ebpc_pkg::ebpc_req_type busReq,     // core bus request
  output      logic [15:0]          busRdata,     // external read data
  output      logic                 busDone,      // cycle finished
  input  wire logic [7:0]           port_a_pins_i,  // port A pin level
  output      logic [7:0]           port_a_pins_o,  // port A drive
  output      logic [7:0]           port_a_pins_oe, // port A enable
  input  wire logic [7:0]           port_b_pins_i,  // port B pin level
  output      logic [7:0]           port_b_pins_o,  // port B drive
  output      logic [7:0]           port_b_pins_oe, // port B enable
  input  wire logic [7:0]           port_e_pins_i,  // port E pin level
  output      logic [7:0]           port_e_pins_o,  // port E drive
  output      logic [7:0]           port_e_pins_oe, // port E enable
  output      logic [7:0]           port_e_pullup   // pull-up enables
);
  logic [7:0] portADataFf, portBDataFf, portADirFf, portBDirFf;
  logic [7:0] portEDataFf, portEDirFf, asgnFf, modeFf, pullFf, miscFf;
  logic [2:0] busModeFf;
  logic       expanded, narrow, periph, emulateE;
  logic       regHit, extHit;
  logic [1:0] phaseFf;
  logic       eClockFf;
  logic       cycActiveFf;
  ebpc_pkg::ebpc_req_type reqFf;
  ebpc_pkg::ebpc_ctl_type ctl;
  logic       followNarrow;
  logic [15:0] swapData;
  logic [15:0] rdCapture;

  assign busModeFf = modeFf[ebpc_pkg::MODE_M0 +: 3];
  assign expanded  = busModeFf == ebpc_pkg::EBPC_EXP_NARR
                  || busModeFf == ebpc_pkg::EBPC_EXP_WIDE;
  assign narrow    = busModeFf == ebpc_pkg::EBPC_EXP_NARR;
  assign periph    = busModeFf == ebpc_pkg::EBPC_PERIPH;
  assign emulateE  = modeFf[ebpc_pkg::MODE_EME];

  // on-chip presence of a register offset for the current mode
  function automatic logic onChip(input logic [15:0] a);
    logic r;
    r = 1'b1;
    if (periph && a < ebpc_pkg::EXPANSION_REGS)
      r = 1'b0;
    if (expanded && (a == ebpc_pkg::OFS_PORT_A_DATA
        || a == ebpc_pkg::OFS_PORT_B_DATA
        || a == ebpc_pkg::OFS_PORT_A_DIR
        || a == ebpc_pkg::OFS_PORT_B_DIR))
      r = 1'b0;
    if (((expanded && emulateE) || periph)
        && (a == ebpc_pkg::OFS_PORT_E_DATA
        || a == ebpc_pkg::OFS_PORT_E_DIR))
      r = 1'b0;
    return r;
  endfunction : onChip

  assign regHit = onChip(regAddr);
  assign extHit = (regWr || regRd) && !regHit;

  // software-visible registers; mode control steers the pin muxing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      portADataFf <= ebpc_pkg::RST_PORT;
      portBDataFf <= ebpc_pkg::RST_PORT;
      portADirFf  <= ebpc_pkg::RST_PORT;
      portBDirFf  <= ebpc_pkg::RST_PORT;
      portEDataFf <= ebpc_pkg::RST_PORT;
      portEDirFf  <= ebpc_pkg::RST_PORT;
      asgnFf      <= ebpc_pkg::RST_ASGN;
      modeFf      <= ebpc_pkg::RST_MODE;
      pullFf      <= ebpc_pkg::RST_PORT;
      miscFf      <= ebpc_pkg::RST_MISC;
    end else if (regWr && regHit) begin
      case (regAddr)
        ebpc_pkg::OFS_PORT_A_DATA: portADataFf <= regWdata;
        ebpc_pkg::OFS_PORT_B_DATA: portBDataFf <= regWdata;
        ebpc_pkg::OFS_PORT_A_DIR:  portADirFf  <= regWdata;
        ebpc_pkg::OFS_PORT_B_DIR:  portBDirFf  <= regWdata;
        ebpc_pkg::OFS_PORT_E_DATA: portEDataFf <= regWdata;
        ebpc_pkg::OFS_PORT_E_DIR:
          portEDirFf <= regWdata & ebpc_pkg::PORT_E_OUT_MASK;
        ebpc_pkg::OFS_PORT_E_ASGN: asgnFf      <= regWdata;
        ebpc_pkg::OFS_MODE_CTRL:   modeFf      <= regWdata;
        ebpc_pkg::OFS_PULL_CTRL:   pullFf      <= regWdata;
        ebpc_pkg::OFS_MISC_CTRL:   miscFf      <= regWdata;
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      regRdata    <= 8'h00;
      regExternal <= 1'b0;
    end else begin
      regExternal <= extHit;
      regRdata    <= 8'h00;
      if (regRd && regHit) begin
        case (regAddr)
          ebpc_pkg::OFS_PORT_A_DATA: regRdata <=
            (portADirFf & portADataFf) | (~portADirFf & port_a_pins_i);
          ebpc_pkg::OFS_PORT_B_DATA: regRdata <=
            (portBDirFf & portBDataFf) | (~portBDirFf & port_b_pins_i);
          ebpc_pkg::OFS_PORT_A_DIR:  regRdata <= portADirFf;
          ebpc_pkg::OFS_PORT_B_DIR:  regRdata <= portBDirFf;
          ebpc_pkg::OFS_PORT_E_DATA: regRdata <=
            (portEDirFf & portEDataFf) | (~portEDirFf & port_e_pins_i);
          ebpc_pkg::OFS_PORT_E_DIR:  regRdata <= portEDirFf;
          ebpc_pkg::OFS_PORT_E_ASGN: regRdata <= asgnFf;
          ebpc_pkg::OFS_MODE_CTRL:   regRdata <= modeFf;
          ebpc_pkg::OFS_PULL_CTRL:   regRdata <= pullFf;
          ebpc_pkg::OFS_MISC_CTRL:   regRdata <= miscFf;
          ebpc_pkg::OFS_BUS_STATUS:  regRdata <=
            {5'h00, cycActiveFf, narrow, expanded};
          default: regRdata <= 8'h00;
        endcase
      end
    end
  end

  // bus cycle: address phase then data phase, E clock high in data
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cycActiveFf <= 1'b0;
      phaseFf     <= 2'h0;
      eClockFf    <= 1'b0;
      reqFf       <= '0;
    end else if (!cycActiveFf) begin
      eClockFf <= 1'b0;
      if (busReq.valid && expanded) begin
        cycActiveFf <= 1'b1;
        reqFf       <= busReq;
        phaseFf     <= 2'h0;
      end
    end else begin
      phaseFf  <= phaseFf + 2'h1;
      // E drops on the closing edge so no data drive leaks into idle
      eClockFf <= phaseFf >= 2'(ebpc_pkg::E_CLOCK_OUT_DIV - 1)
               && phaseFf != 2'(2 * ebpc_pkg::E_CLOCK_OUT_DIV - 1);
      if (phaseFf == 2'(2 * ebpc_pkg::E_CLOCK_OUT_DIV - 1))
        cycActiveFf <= 1'b0;
    end
  end

  assign busDone = cycActiveFf
                && phaseFf == 2'(2 * ebpc_pkg::E_CLOCK_OUT_DIV - 1);

  assign followNarrow = !narrow && miscFf[ebpc_pkg::MISC_NARR]
    && reqFf.addr >= ebpc_pkg::FOLLOW_BASE
    && reqFf.addr < ebpc_pkg::FOLLOW_BASE + ebpc_pkg::FOLLOW_SIZE;

  ebpc_encode u_encode (
    .wide   (reqFf.wide),
    .write  (reqFf.write),
    .odd    (reqFf.addr[0]),
    .ramHit (reqFf.ramHit),
    .ctl    (ctl)
  );

  assign swapData = (ctl.strobeN && ctl.a0 && reqFf.wide)
    ? {reqFf.wdata[7:0], reqFf.wdata[15:8]} : reqFf.wdata;

  assign rdCapture = {port_a_pins_i, port_b_pins_i};

  // capture read data at the end of the data phase
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      busRdata <= 16'h0000;
    else if (busDone && !reqFf.write)
      busRdata <= (narrow || followNarrow)
        ? {8'h00, port_a_pins_i} : rdCapture;
  end

  // port A/B pins: address in phase 0/1, data in E-high phase; narrow accesses keep the low address on port B then
  always_comb begin
    port_a_pins_o  = portADataFf;
    port_b_pins_o  = portBDataFf;
    port_a_pins_oe = portADirFf;
    port_b_pins_oe = portBDirFf;
    if (expanded) begin
      port_a_pins_o  = reqFf.addr[15:8];
      port_b_pins_o  = reqFf.addr[7:0];
      port_a_pins_oe = {8{cycActiveFf}};
      port_b_pins_oe = {8{cycActiveFf}};
      if (eClockFf) begin
        port_a_pins_oe = {8{reqFf.write}};
        if (narrow || followNarrow) begin
          port_a_pins_o  = reqFf.addr[0] ? swapData[15:8]
                                         : swapData[7:0];
          port_b_pins_oe = {8{cycActiveFf}};
        end else begin
          port_a_pins_o  = swapData[15:8];
          port_b_pins_o  = swapData[7:0];
          port_b_pins_oe = {8{reqFf.write}};
        end
      end
    end
  end

  always_comb begin
    port_e_pins_o  = portEDataFf;
    port_e_pins_oe = portEDirFf & ebpc_pkg::PORT_E_OUT_MASK;
    if (expanded) begin
      if (!asgnFf[ebpc_pkg::ASGN_DBE]) begin
        port_e_pins_o[7]  = ~eClockFf;
        port_e_pins_oe[7] = 1'b1;
      end
      if (asgnFf[ebpc_pkg::ASGN_PIPE]) begin
        port_e_pins_o[6:5]  = 2'h0;
        port_e_pins_oe[6:5] = 2'h3;
      end
      if (!asgnFf[ebpc_pkg::ASGN_E_CLOCK_OUT]) begin
        port_e_pins_o[4]  = eClockFf;
        port_e_pins_oe[4] = 1'b1;
      end
      if (asgnFf[ebpc_pkg::ASGN_STRB] && !narrow) begin
        port_e_pins_o[3]  = cycActiveFf ? ctl.strobeN : 1'b1;
        port_e_pins_oe[3] = 1'b1;
      end
      if (asgnFf[ebpc_pkg::ASGN_RDW]) begin
        port_e_pins_o[2]  = cycActiveFf ? ctl.readWrite : 1'b1;
        port_e_pins_oe[2] = 1'b1;
      end
    end
    port_e_pins_oe[1:0] = 2'h0;
  end

  always_comb begin
    port_e_pullup = {8{pullFf[ebpc_pkg::PULL_PUPE]}}
                  & ~port_e_pins_oe & 8'h8F;
  end
endmodule : ebpc_port_control

// ===== bench/ebpc_port_control_props.sv
`timescale 1ns/100ps
// port-control watcher; strobe sits on port E bit 3, R/W on bit 2
module ebpc_port_control_props (
  input wire logic                   ref_clk,        // bus clock
  input wire logic                   reset,          // async reset
  input wire logic                   regWr,          // write strobe
  input wire logic                   regRd,          // read strobe
  input wire logic [7:0]             regRdata,       // read data
  input wire logic                   regExternal,    // went outside
  input wire ebpc_pkg::ebpc_req_type busReq,         // core request
  input wire logic                   busDone,        // cycle end
  input wire logic [7:0]             port_e_pins_o,  // port E drive
  input wire logic [7:0]             port_e_pins_oe, // port E enable
  input wire logic [7:0]             port_e_pullup   // pull-ups
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // encoding is judged in the last phase, when the request is still held
  wire ctlOn = busDone && busReq.valid;
  AST_RDATA_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_EXT_CAUSE: assert property (regExternal |-> $past(regRd) || $past(regWr))
    else $error("external flag without an access");
  AST_DONE_GAP: assert property (busDone |=> !busDone [*4])
    else $error("bus cycles closer than one full cycle");
  AST_RW_CODE: assert property (ctlOn && port_e_pins_oe[2] |-> port_e_pins_o[2] == !busReq.write)
    else $error("read/write pin wrong");
  AST_STRB_BYTE: assert property (ctlOn && !busReq.wide && port_e_pins_oe[3] |-> port_e_pins_o[3] == !busReq.addr[0])
    else $error("byte strobe wrong");
  AST_STRB_WORD: assert property (ctlOn && busReq.wide && port_e_pins_oe[3] |-> port_e_pins_o[3] == (busReq.addr[0] && busReq.ramHit))
    else $error("word strobe wrong");
  AST_PE_IN_ONLY: assert property (port_e_pins_oe[1:0] == 2'b00)
    else $error("interrupt pin driven");
  AST_PULL_OUT: assert property ((port_e_pullup & port_e_pins_oe) == 8'h00)
    else $error("pull-up on an output");
  AST_PULL_SET: assert property ((port_e_pullup & 8'h70) == 8'h00)
    else $error("pull-up on a pin without one");
endmodule : ebpc_port_control_props
bind ebpc_port_control ebpc_port_control_props chk (.ref_clk(ref_clk),
  .reset(reset), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .regExternal(regExternal), .busReq(busReq), .busDone(busDone),
  .port_e_pins_o(port_e_pins_o), .port_e_pins_oe(port_e_pins_oe),
  .port_e_pullup(port_e_pullup));

// ===== bench/ebpc_bus_memory.sv
`timescale 1ns/100ps
// memory on the multiplexed bus: answers reads with the inverted address
module ebpc_bus_memory (
  input  wire logic [7:0] aO,      // port A drive
  input  wire logic       ref_clk, // bus clock
  input  wire logic [7:0] aOe,     // port A enable
  input  wire logic [7:0] bO,      // port B drive
  input  wire logic [7:0] bOe,     // port B enable
  input  wire logic [7:0] eO,      // port E drive
  input  wire logic [7:0] eOe,     // port E enable
  input  wire logic [7:0] eExt,    // outside port E level
  output      logic [7:0] aPin,    // resolved port A
  output      logic [7:0] bPin,    // resolved port B
  output      logic [7:0] ePin     // resolved port E
);
  logic [15:0] addrFf = 16'h0000; // latched address
  logic        phaseFf = 1'b0;    // address phase last cycle
  logic [7:0]  lastA = 8'h00;     // last port A level
  logic [7:0]  lastB = 8'h00;     // last port B level
  wire         addrPh = &{aOe, bOe};
  wire         rdSel = eOe[2] & eO[2];
  // latch on the first driven cycle only: write data drives both ports too
  always @(posedge ref_clk) begin
    phaseFf <= addrPh;
    lastA <= (aOe & aO) | (~aOe & lastA);
    lastB <= (bOe & bO) | (~bOe & lastB);
    if (addrPh && !phaseFf) begin
      addrFf <= {aO, bO};
    end
  end
  // a released line shows the inverted latched address while R/W drives high, else the inverse of its last level
  assign aPin = (aOe & aO) | (~aOe & (rdSel ? ~addrFf[15:8] : ~lastA));
  assign bPin = (bOe & bO) | (~bOe & (rdSel ? ~addrFf[7:0] : ~lastB));
  assign ePin = (eOe & eO) | (~eOe & eExt);
endmodule : ebpc_bus_memory

// ===== bench/ebpc_port_control_tb.sv
`timescale 1ns/100ps
// register and bus-cycle regression for the port control block
module ebpc_port_control_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] eExt = 8'h00;
  logic [7:0] regRdata, aO, aOe, bO, bOe, eO, eOe, pull, aPin, bPin, ePin;
  logic regExternal, busDone;
  logic [15:0] busRdata;
  ebpc_pkg::ebpc_req_type busReq = '0;
  logic [3:0] ks [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'hC, 4'hB, 4'hF};
  int n_errors = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  ebpc_port_control uut (.ref_clk(ref_clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .regExternal(regExternal), .busReq(busReq),
    .busRdata(busRdata), .busDone(busDone), .port_a_pins_i(aPin),
    .port_a_pins_o(aO), .port_a_pins_oe(aOe), .port_b_pins_i(bPin),
    .port_b_pins_o(bO), .port_b_pins_oe(bOe), .port_e_pins_i(ePin),
    .port_e_pins_o(eO), .port_e_pins_oe(eOe), .port_e_pullup(pull));
  ebpc_bus_memory mem (.ref_clk(ref_clk), .aO(aO), .aOe(aOe), .bO(bO),
    .bOe(bOe), .eO(eO), .eOe(eOe), .eExt(eExt), .aPin(aPin),
    .bPin(bPin), .ePin(ePin));
  task automatic print_verdict;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // one strobe cycle; answer and outside flag are judged a cycle later
  task automatic acc(input logic wr, input logic [15:0] a,
                     input logic [7:0] d, input logic ext);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= wr;
    regRd <= !wr;
    @(posedge ref_clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0, regExternal}, {15'h0, ext}); // outside flag
    if (!wr && !ext) chk({8'h00, regRdata}, {8'h00, d}); // read back
  endtask : acc
  // k is {wide, write, odd, ram}; the request is held until done
  task automatic bus(input logic [3:0] k);
    logic seen;
    logic [15:0] a;
    seen = 1'b0;
    a = 16'h1234 | {15'h0, k[1]};
    @(posedge ref_clk);
    busReq <= '{1'b1, k[2], k[3], k[0], a, 16'hC3A5};
    for (int i = 0; i < 20 && !busDone; i++) begin
      @(negedge ref_clk);
      if (!seen && &{aOe, bOe}) begin
        seen = 1'b1;
        chk({aO, bO}, a); // address with A0
      end
    end
    chk({15'h0, busDone}, 16'h0001); // cycle ends
    chk({14'h0, eO[3:2]}, {14'h0, k[3] ? k[1] & k[0] : !k[1], !k[2]});
    @(posedge ref_clk);
    busReq <= '0;
    @(posedge ref_clk);
    if (k == 4'h8) chk(busRdata, ~a); // word read
  endtask : bus
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  // main sequence: single-chip GPIO, then expanded, then peripheral
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    chk({aOe, bOe}, 16'h0000); // inputs at reset
    acc(1'b0, ebpc_pkg::OFS_PORT_A_DIR, 8'h00, 1'b0); // reset value
    acc(1'b0, 16'h0007, 8'h00, 1'b0); // unmapped place
    @(posedge ref_clk);
    busReq <= '{1'b1, 1'b0, 1'b1, 1'b0, 16'h1234, 16'h0000};
    repeat (8) @(negedge ref_clk) chk({15'h0, busDone}, 16'h0);
    @(posedge ref_clk);
    busReq <= '0;
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, i ? ebpc_pkg::OFS_PORT_B_DIR : ebpc_pkg::OFS_PORT_A_DIR,
          8'h0F, 1'b0); // direction
      acc(1'b1, i[15:0], 8'hA5, 1'b0); // data write
      acc(1'b0, i[15:0], 8'hF5, 1'b0); // data read
      chk(i ? {bOe, bO} : {aOe, aO}, 16'h0FA5); // drive
    end
    acc(1'b1, ebpc_pkg::OFS_PORT_E_DIR, 8'hFF, 1'b0); // all out
    chk({8'h00, eOe}, 16'h00FC); // bits 1:0 stay in
    eExt <= 8'h5A;
    acc(1'b1, ebpc_pkg::OFS_PORT_E_DIR, 8'h0C, 1'b0); // direction
    acc(1'b1, ebpc_pkg::OFS_PULL_CTRL, 8'h01, 1'b0); // pull enable
    acc(1'b0, ebpc_pkg::OFS_PORT_E_DATA, 8'h52, 1'b0); // pins read
    chk({8'h00, pull}, 16'h0083); // input pins only
    acc(1'b1, ebpc_pkg::OFS_MODE_CTRL, 8'h60, 1'b0); // wide mode
    acc(1'b1, ebpc_pkg::OFS_PORT_E_ASGN, 8'h0C, 1'b0); // strobe, R/W
    acc(1'b0, ebpc_pkg::OFS_BUS_STATUS, 8'h01, 1'b0); // expanded idle
    acc(1'b0, ebpc_pkg::OFS_PORT_A_DATA, 8'h00, 1'b1); // removed
    acc(1'b1, ebpc_pkg::OFS_PORT_B_DIR, 8'hFF, 1'b1); // removed
    acc(1'b1, ebpc_pkg::OFS_PORT_E_DATA, 8'h00, 1'b0); // still mapped
    acc(1'b1, ebpc_pkg::OFS_MODE_CTRL, 8'h61, 1'b0); // emulate port E
    acc(1'b1, ebpc_pkg::OFS_PORT_E_DIR, 8'h00, 1'b1); // removed
    acc(1'b0, ebpc_pkg::OFS_PORT_E_DATA, 8'h00, 1'b1); // removed
    for (int i = 0; i < 8; i++) bus(ks[i]); // every encoding
    acc(1'b1, ebpc_pkg::OFS_MODE_CTRL, 8'h40, 1'b0); // peripheral
    acc(1'b0, 16'h000F, 8'h00, 1'b1); // first sixteen gone
    acc(1'b0, ebpc_pkg::OFS_PORT_E_DATA, 8'h00, 1'b1); // removed
    print_verdict();
  end
endmodule : ebpc_port_control_tb
